/* asd_map.vh */
// Constants of the audio sample FIFO DMA unit
`ifndef ASD_MAP_VH
`define ASD_MAP_VH
`define ASD_DEPTH      9'h180
`define ASD_HALF       9'h0c0
`define ASD_AW         9
`define ASD_DW         16
`define ASD_MODE_MONO  2'h0
`define ASD_MODE_SIMPLE 2'h1
`define ASD_MODE_MIXED 2'h2
`define ASD_MODE_FULL  2'h3
`define ASD_MUTE_WORD  16'h0000
`define ASD_RST_WORD   16'h0000
`define ASD_RST_ADDR   9'h000
`endif

/* asd_fifo_mem.v */
// Dual-port FIFO memory with registered read data
`default_nettype none
`include "asd_map.vh"
module asd_fifo_mem (
  input  wire                clock,
  input  wire                a_we,
  input  wire [`ASD_AW-1:0]  a_addr,
  input  wire [`ASD_DW-1:0]  a_wdata,
  output reg  [`ASD_DW-1:0]  a_rdata,
  input  wire                b_we,
  input  wire [`ASD_AW-1:0]  b_addr,
  input  wire [`ASD_DW-1:0]  b_wdata,
  output reg  [`ASD_DW-1:0]  b_rdata
);
  reg [`ASD_DW-1:0] mem [0:383];

  // Port A is the DMA side; written last so it wins an address clash
  always @(posedge clock) begin
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
  end
endmodule // asd_fifo_mem
`default_nettype wire

/* asd_dma.v */
// Audio sample FIFO DMA unit with shared FIFO memories and smart views
`default_nettype none
`include "asd_map.vh"
module asd_dma (
  input  wire                clock,
  input  wire                reset_n,
  input  wire                dma_enable,
  input  wire [1:0]          pack_mode,
  input  wire [`ASD_AW-1:0]  block_words,
  input  wire                automute_en,
  input  wire                battery_eol,
  input  wire                adc_valid,
  input  wire                adc_chan,
  input  wire [`ASD_DW-1:0]  adc_data,
  input  wire                dac_ready,
  output reg                 dac_valid,
  output reg                 dac_chan,
  output reg  [`ASD_DW-1:0]  dac_data,
  output reg                 block_full_irq,
  input  wire                core_en,
  input  wire                core_we,
  input  wire                core_fifo_sel,
  input  wire                core_smart,
  input  wire [`ASD_AW-1:0]  core_addr,
  input  wire [`ASD_DW-1:0]  core_wdata,
  output reg  [`ASD_DW-1:0]  core_rdata,
  input  wire                cop_en,
  input  wire                cop_we,
  input  wire                cop_fifo_sel,
  input  wire [`ASD_AW-1:0]  cop_addr,
  input  wire [`ASD_DW-1:0]  cop_wdata,
  output reg  [`ASD_DW-1:0]  cop_rdata
);
  // Input side pointers
  reg  [`ASD_AW-1:0] cnt0_q, cnt1_q, in_lin_q, in_blk_q, in_base_q;
  // Output side pointers
  reg  [`ASD_AW-1:0] ocnt_q, out_lin_q, out_blk_q, out_base_q;
  reg                pend_q, pend_ch_q;
  reg                v1_q, c1_q;
  reg  [`ASD_DW-1:0] d1_q;
  reg                core_sel_q, cop_sel_q, cop_act_q, core_act_q;
  wire [`ASD_DW-1:0] in_a_rd, in_b_rd, out_a_rd, out_b_rd;

  // Input write address per packing mode
  reg  [`ASD_AW-1:0] in_addr, chan_cnt, chan_nxt, wrap;
  wire               in_wr = dma_enable & adc_valid;
  always @* begin
    chan_cnt = adc_chan ? cnt1_q : cnt0_q;
    wrap     = (pack_mode == `ASD_MODE_MONO) ? `ASD_DEPTH : `ASD_HALF;
    chan_nxt = (chan_cnt + 9'h001 >= wrap) ? 9'h000 : chan_cnt + 9'h001;
    case (pack_mode)
      `ASD_MODE_MONO:   in_addr = cnt0_q;
      `ASD_MODE_SIMPLE: in_addr = {chan_cnt[7:0], adc_chan};
      `ASD_MODE_MIXED:  in_addr = adc_chan ? chan_cnt + `ASD_HALF : chan_cnt;
      `ASD_MODE_FULL:   in_addr = {chan_cnt[7:0], adc_chan};
      default:          in_addr = cnt0_q;
    endcase
  end

  // Output read address: full stereo alternates channels, mono and full stereo use the whole FIFO, the other two modes its lower half
  reg  [`ASD_AW-1:0] out_addr, ocnt_nxt;
  // Occupancy counts the head word, the spare slot and the fetch in flight
  wire [1:0]         fill = {1'b0, dac_valid} + {1'b0, v1_q} + {1'b0, pend_q};
  wire               out_rd = dma_enable & (fill < 2'h2);
  always @* begin
    case (pack_mode)
      `ASD_MODE_MONO:   out_addr = ocnt_q;
      `ASD_MODE_SIMPLE: out_addr = ocnt_q;
      `ASD_MODE_MIXED:  out_addr = ocnt_q;
      `ASD_MODE_FULL:   out_addr = ocnt_q;
      default:          out_addr = ocnt_q;
    endcase
    ocnt_nxt = (ocnt_q + 9'h001 >= ((pack_mode == `ASD_MODE_MONO ||
                pack_mode == `ASD_MODE_FULL) ? `ASD_DEPTH : `ASD_HALF)) ?
               9'h000 : ocnt_q + 9'h001;
  end

  // Linear position wraps used by block tracking and the smart views
  function [`ASD_AW-1:0] asd_wrap_add;
    input [`ASD_AW-1:0] a;
    input [`ASD_AW-1:0] b;
    reg   [`ASD_AW:0]   s;
    begin
      s = {1'b0, a} + {1'b0, b};
      asd_wrap_add = (s >= {1'b0, `ASD_DEPTH}) ? s[`ASD_AW-1:0] - `ASD_DEPTH : s[`ASD_AW-1:0];
    end
  endfunction

  // Shared port: coprocessor has priority over the core, neither moves pointers
  wire               b_cop = cop_en;
  wire               b_sel = b_cop ? cop_fifo_sel : core_fifo_sel;
  wire               b_we  = b_cop ? cop_we : (core_en & core_we);
  wire [`ASD_DW-1:0] b_wd  = b_cop ? cop_wdata : core_wdata;
  reg  [`ASD_AW-1:0] b_addr;
  always @* begin
    if (b_cop) begin
      b_addr = cop_addr;
    end else if (core_smart) begin
      // Smart view offset 0 is the linear start of the newest complete input block or of the output block being fetched; older ones sit behind it
      b_addr = asd_wrap_add(core_fifo_sel ? out_base_q : in_base_q,
                            core_addr >= `ASD_DEPTH ? 9'h000 : core_addr);
    end else begin
      b_addr = core_addr;
    end
  end

  asd_fifo_mem u_in_mem (
    .clock   (clock),
    .a_we    (in_wr),
    .a_addr  (in_addr),
    .a_wdata (adc_data),
    .a_rdata (in_a_rd),
    .b_we    (b_we & ~b_sel),
    .b_addr  (b_addr),
    .b_wdata (b_wd),
    .b_rdata (in_b_rd)
  );

  asd_fifo_mem u_out_mem (
    .clock   (clock),
    .a_we    (1'b0),
    .a_addr  (out_addr),
    .a_wdata (`ASD_RST_WORD),
    .a_rdata (out_a_rd),
    .b_we    (b_we & b_sel),
    .b_addr  (b_addr),
    .b_wdata (b_wd),
    .b_rdata (out_b_rd)
  );

  // Pointer and block tracking; a block ends after block_words linear words
  wire in_blk_end  = in_wr & (in_blk_q + 9'h001 >= block_words);
  wire out_blk_end = out_rd & (out_blk_q + 9'h001 >= block_words);
  always @(posedge clock) begin
    if (!reset_n) begin
      cnt0_q         <= `ASD_RST_ADDR;
      cnt1_q         <= `ASD_RST_ADDR;
      in_lin_q       <= `ASD_RST_ADDR;
      in_blk_q       <= `ASD_RST_ADDR;
      in_base_q      <= `ASD_RST_ADDR;
      ocnt_q         <= `ASD_RST_ADDR;
      out_lin_q      <= `ASD_RST_ADDR;
      out_blk_q      <= `ASD_RST_ADDR;
      out_base_q     <= `ASD_RST_ADDR;
      block_full_irq <= 1'b0;
    end else begin
      block_full_irq <= in_blk_end;
      if (in_wr) begin
        if (adc_chan) cnt1_q <= chan_nxt;
        else          cnt0_q <= chan_nxt;
        in_lin_q <= asd_wrap_add(in_lin_q, 9'h001);
        in_blk_q <= in_blk_end ? 9'h000 : in_blk_q + 9'h001;
        if (in_blk_end) begin
          // Newest complete block starts block_words-1 behind this word
          in_base_q <= asd_wrap_add(in_lin_q, `ASD_DEPTH - block_words + 9'h001);
        end
      end
      if (out_rd) begin
        ocnt_q    <= ocnt_nxt;
        out_lin_q <= asd_wrap_add(out_lin_q, 9'h001);
        out_blk_q <= out_blk_end ? 9'h000 : out_blk_q + 9'h001;
        if (out_blk_end) begin
          out_base_q <= asd_wrap_add(out_lin_q, 9'h001);
        end
      end
    end
  end

  // Two-entry output buffer; reads are issued only with a free slot, so no word is lost
  wire               pop     = dac_valid & dac_ready;
  wire [`ASD_DW-1:0] push_d  = (automute_en & battery_eol) ? `ASD_MUTE_WORD : out_a_rd;
  always @(posedge clock) begin
    if (!reset_n) begin
      pend_q    <= 1'b0;
      pend_ch_q <= 1'b0;
      dac_valid <= 1'b0;
      dac_chan  <= 1'b0;
      dac_data  <= `ASD_RST_WORD;
      v1_q      <= 1'b0;
      c1_q      <= 1'b0;
      d1_q      <= `ASD_RST_WORD;
    end else begin
      pend_q    <= out_rd;
      pend_ch_q <= (pack_mode == `ASD_MODE_FULL) & ocnt_q[0];
      if (pop | ~dac_valid) begin
        if (v1_q) begin
          dac_valid <= 1'b1;
          dac_chan  <= c1_q;
          dac_data  <= d1_q;
          v1_q      <= pend_q;
          c1_q      <= pend_ch_q;
          d1_q      <= push_d;
        end else begin
          dac_valid <= pend_q;
          dac_chan  <= pend_ch_q;
          dac_data  <= push_d;
        end
      end else if (pend_q) begin
        v1_q <= 1'b1;
        c1_q <= pend_ch_q;
        d1_q <= push_d;
      end
    end
  end

  // Shared read data, registered once more so the ports come from flip-flops
  always @(posedge clock) begin
    if (!reset_n) begin
      core_sel_q <= 1'b0;
      cop_sel_q  <= 1'b0;
      cop_act_q  <= 1'b0;
      core_act_q <= 1'b0;
      core_rdata <= `ASD_RST_WORD;
      cop_rdata  <= `ASD_RST_WORD;
    end else begin
      core_sel_q <= b_sel;
      cop_sel_q  <= b_sel;
      cop_act_q  <= b_cop;
      core_act_q <= core_en & ~b_cop;
      if (core_act_q) core_rdata <= core_sel_q ? out_b_rd : in_b_rd;
      if (cop_act_q)  cop_rdata  <= cop_sel_q ? out_b_rd : in_b_rd;
    end
  end
endmodule // asd_dma
`default_nettype wire

/* asd_props.sv */
// Port-level checks of the audio sample FIFO DMA unit
`default_nettype none
`include "asd_map.vh"
module asd_props (
  input wire logic               clock,
  input wire logic               reset_n,
  input wire logic               dma_enable,
  input wire logic [1:0]         pack_mode,
  input wire logic [`ASD_AW-1:0] block_words,
  input wire logic               automute_en,
  input wire logic               battery_eol,
  input wire logic               adc_valid,
  input wire logic               dac_ready,
  input wire logic               dac_valid,
  input wire logic               dac_chan,
  input wire logic [`ASD_DW-1:0] dac_data,
  input wire logic               block_full_irq,
  input wire logic               core_en,
  input wire logic               cop_en,
  input wire logic [`ASD_DW-1:0] core_rdata,
  input wire logic [`ASD_DW-1:0] cop_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [1:0] mute_seen_q;
  // Up to two words may already be buffered or in flight when mute starts
  always @(posedge clock) begin
    if (!reset_n || !(automute_en && battery_eol)) mute_seen_q <= 2'h0;
    else if (dac_valid && dac_ready && mute_seen_q != 2'h3) mute_seen_q <= mute_seen_q + 2'h1;
  end
  chk_irq_single: assert property (block_full_irq && block_words > 9'h001 |=> !block_full_irq)
    else $error("block-full pulse longer than one cycle");
  chk_irq_cause: assert property ($rose(block_full_irq) |->
    $past(adc_valid) && $past(dma_enable))
    else $error("block-full pulse without a sample write");
  chk_dac_hold: assert property (dac_valid && !dac_ready |=> dac_valid && $stable({dac_chan, dac_data}))
    else $error("output word changed while stalled");
  chk_dac_side: assert property (dac_valid && pack_mode != `ASD_MODE_FULL |-> !dac_chan)
    else $error("second output channel used outside full stereo");
  chk_idle_out: assert property ((!dma_enable)[*6] ##0 !dac_valid |=> !dac_valid)
    else $error("output word appeared with the unit disabled");
  chk_mute_zero: assert property (automute_en && battery_eol && mute_seen_q >= 2'h2 &&
    dac_valid && dac_ready |-> dac_data == `ASD_MUTE_WORD)
    else $error("nonzero output word under automute");
  chk_core_hold: assert property (!core_en || cop_en |-> ##2 $stable(core_rdata))
    else $error("core read data changed without a request");
  chk_cop_hold: assert property (!cop_en |-> ##2 $stable(cop_rdata))
    else $error("coprocessor read data changed without a request");
  chk_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !dac_valid && !block_full_irq)
    else $error("outputs active after a reset edge");
  // Main scenarios reached
  cov_irq: cover property (block_full_irq);
  cov_stall: cover property (dac_valid && !dac_ready);
  cov_chan: cover property (dac_valid && dac_chan);
endmodule // asd_props
bind asd_dma asd_props u_asd_props (.clock, .reset_n, .dma_enable, .pack_mode, .block_words,
  .automute_en, .battery_eol, .adc_valid, .dac_ready, .dac_valid, .dac_chan, .dac_data,
  .block_full_irq, .core_en, .cop_en, .core_rdata, .cop_rdata);
`default_nettype wire

/* asd_sink.sv */
// Output stage model that takes words with random stalls
`default_nettype none
module asd_sink (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic dac_valid,
  output var  logic dac_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial dac_ready = 1'b0;
  // Ready moves just after an edge; stalls only while a word waits
  always @(posedge clock) begin
    #2 dac_ready = reset_n && (!dac_valid || $urandom_range(3) != 0);
  end
endmodule // asd_sink
`default_nettype wire

/* asd_dma_bench.sv */
// Self-checking bench of the audio sample FIFO DMA unit
`default_nettype none
`include "asd_map.vh"
module asd_dma_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NW = 8; // Two blocks of four words per pass
  logic        clock = 1'b0, reset_n = 1'b0, dma_enable = 1'b0, automute_en = 1'b0;
  logic        battery_eol = 1'b0, adc_valid = 1'b0, adc_chan = 1'b0, dac_ready, dac_valid;
  logic        dac_chan, block_full_irq, core_en = 1'b0, core_smart = 1'b0, cop_en = 1'b0;
  logic        core_fifo_sel = 1'b0, cp_chk = 1'b0;
  logic [1:0]  pack_mode = 2'h0;
  logic [8:0]  block_words = 9'h004, core_addr = 9'h000, cop_addr = 9'h000, in_a[NW];
  logic [15:0] adc_data = 16'h0000, dac_data, core_rdata, cop_rdata, cop_wdata = 16'h0000;
  logic [15:0] rd_q[$], in_d[NW], cp_q[$], out_m[NW];
  logic [16:0] dac_q[$];
  logic [1:0]  rd_sh = 2'h0;
  logic [1:0]  cp_sh = 2'h0;
  int          num_errors = 0, checked = 0, irqs = 0, irq0 = 0;
  asd_dma u_asd_dma (.clock, .reset_n, .dma_enable, .pack_mode, .block_words, .automute_en,
    .battery_eol, .adc_valid, .adc_chan, .adc_data, .dac_ready, .dac_valid, .dac_chan,
    .dac_data, .block_full_irq, .core_en, .core_we(1'b0), .core_fifo_sel, .core_smart,
    .core_addr, .core_wdata(16'h0000), .core_rdata, .cop_en, .cop_we(cop_en),
    .cop_fifo_sel(1'b1), .cop_addr, .cop_wdata, .cop_rdata);
  asd_sink u_asd_sink (.clock, .reset_n, .dac_valid, .dac_ready);
  always #25 clock = ~clock;
  task automatic step(int n = 1);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic cmp_dac(logic [16:0] g, logic [16:0] e);
    checked++;
    if (g !== e) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end
  endtask
  task automatic cmp_rd(logic [15:0] g, logic [15:0] e);
    checked++;
    if (g !== e) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end
  endtask
  task automatic cmp_cnt(int g, int e);
    checked++;
    if (g != e) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end
  endtask
  task automatic end_sim;
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Read data shows two edges after the request and is checked on the third; output words on handshake
  always @(posedge clock) begin
    rd_sh <= {rd_sh[0], core_en & ~cop_en};
    cp_sh <= {cp_sh[0], cop_en & cp_chk};
    if (rd_sh[1]) cmp_rd(core_rdata, rd_q.pop_front());
    if (cp_sh[1]) cmp_rd(cop_rdata, cp_q.pop_front());
    if (reset_n && dac_valid === 1'b1 && dac_ready && dac_q.size() > 0)
      cmp_dac({dac_chan, dac_data}, dac_q.pop_front());
    if (block_full_irq === 1'b1) irqs++;
  end
  // Watchdog far beyond the five passes
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  // One pass per packing mode, plus a fifth pass in full stereo under automute
  initial begin
    void'($urandom(32'hb7a309a7));
    for (int p = 0; p < 5; p++) begin
      reset_n = 1'b0;
      dma_enable = 1'b0;
      pack_mode = (p == 4) ? 2'h3 : p[1:0];
      automute_en = (p == 4);
      battery_eol = (p == 4);
      irq0 = irqs;
      step(3);
      reset_n = 1'b1;
      cop_en = 1'b1;
      // First pass zeroes the whole output FIFO, so fetches past the test words see no unknowns
      for (int i = 0; i < 384 && p == 0; i++) begin
        cop_addr = 9'(i);
        if (i < NW) out_m[i] = 16'h0000;
        step();
      end
      cp_chk = 1'b1;
      // Output FIFO is filled before fetching starts, so the fetch order is known
      for (int i = 0; i < NW; i++) begin
        cop_addr = i[8:0];
        cop_wdata = 16'($urandom);
        cp_q.push_back(out_m[i]);
        out_m[i] = cop_wdata;
        dac_q.push_back({pack_mode == `ASD_MODE_FULL && i[0], (p == 4) ? 16'h0000 : cop_wdata});
        step();
      end
      cop_en = 1'b0;
      cp_chk = 1'b0;
      dma_enable = 1'b1;
      adc_valid = 1'b1;
      // Back-to-back samples; mixed mode splits channels; last pass uses one input only
      for (int k = 0; k < NW; k++) begin
        adc_chan = (pack_mode == `ASD_MODE_MONO || p == 4) ? 1'b0 : k[0];
        adc_data = 16'($urandom);
        in_d[k] = adc_data;
        in_a[k] = (pack_mode == `ASD_MODE_MIXED) ? 9'(k % 2 * 192 + k / 2) :
                  (p == 4) ? 9'(2 * k) : 9'(k);
        step();
      end
      adc_valid = 1'b0;
      step(3);
      cmp_cnt(irqs - irq0, 2);
      core_en = 1'b1;
      for (int k = 0; k < NW; k++) begin
        core_addr = in_a[k];
        rd_q.push_back(in_d[k]);
        step();
      end
      // Smart view: newest block starts at offset zero
      for (int j = 0; j < 2 && p == 0; j++) begin
        core_smart = 1'b1;
        core_addr = 9'(3 * j);
        rd_q.push_back(in_d[4 + 3 * j]);
        step();
      end
      core_smart = 1'b0;
      // Normal view of the output FIFO shows what the coprocessor left there
      core_fifo_sel = 1'b1;
      core_addr = 9'h001;
      rd_q.push_back(out_m[1]);
      step();
      core_fifo_sel = 1'b0;
      core_en = 1'b0;
      for (int w = 0; w < 300 && (dac_q.size() > 0 || rd_q.size() > 0 || cp_q.size() > 0); w++)
        step();
      cmp_cnt(dac_q.size() + rd_q.size() + cp_q.size(), 0);
    end
    end_sim();
  end
endmodule // asd_dma_bench
`default_nettype wire
